/* abms_bus_if.sv */
// Interface carrying the multiplexed backplane between master and memory slave.
`timescale 1ns/100ps
interface abms_bus_if import abms_pkg::*; ();
    logic [ABMS_DW-1:0] ad_m_o;
    logic ad_m_oe;
    logic [ABMS_DW-1:0] ad_s_o;
    logic ad_s_oe;
    logic [ABMS_DW-1:0] ad;
    logic frame_sync;
    logic read_req;
    logic write_req;
    logic write_byte_qualifier;
    logic refresh_active_line;
    logic io_page_select;
    logic slave_reply;
    // Resolved level of the shared lines; idle lines float high.
    assign ad = ad_m_oe ? ad_m_o : (ad_s_oe ? ad_s_o : {ABMS_DW{1'b1}});
    modport master (
        output ad_m_o, ad_m_oe, frame_sync, read_req, write_req,
        output write_byte_qualifier, refresh_active_line, io_page_select,
        input ad, slave_reply
    );
    modport slave (
        output ad_s_o, ad_s_oe, slave_reply,
        input ad, frame_sync, read_req, write_req,
        input write_byte_qualifier, refresh_active_line, io_page_select
    );
endinterface

/* abms_bus_sva.sv */
// Concurrent checks of the backplane handshake between master and memory slave.
`timescale 1ns/100ps
module abms_bus_sva import abms_pkg::*; (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Shared lines and their drivers.
    input wire logic [ABMS_DW-1:0] ad_m_o,
    input wire logic ad_m_oe,
    input wire logic [ABMS_DW-1:0] ad_s_o,
    input wire logic ad_s_oe,
    input wire logic [ABMS_DW-1:0] ad,
    // Framing, strobes and qualifiers.
    input wire logic frame_sync,
    input wire logic read_req,
    input wire logic write_req,
    input wire logic write_byte_qualifier,
    input wire logic refresh_active_line,
    input wire logic io_page_select,
    input wire logic slave_reply
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Steps of one interlocked data phase.
    sequence s_phase_ack;
        (read_req || write_req) && slave_reply;
    endsequence
    sequence s_strobes_gone;
        !read_req && !write_req;
    endsequence
    sequence s_reply_gone;
        !slave_reply;
    endsequence
    // Reply only rises inside a framed data phase, never on its own.
    a_reply_in_phase: assert property ($rose(slave_reply) |-> frame_sync && (read_req || write_req))
        else $error("reply rose outside a data phase");
    a_reply_holds: assert property (s_phase_ack |=> slave_reply)
        else $error("reply dropped while strobe still up");
    a_strobe_release: assert property (s_phase_ack |-> ##[1:8] s_strobes_gone)
        else $error("strobe not released after reply");
    a_reply_release: assert property (s_phase_ack ##[1:8] s_strobes_gone |-> ##[0:8] s_reply_gone)
        else $error("reply not released after strobe drop");
    a_read_waits: assert property (read_req && !slave_reply |=> read_req)
        else $error("read strobe dropped without reply");
    a_write_waits: assert property (write_req && !slave_reply |=> write_req)
        else $error("write strobe dropped without reply");
    // A non-refresh read reply must come with the slave driving the data it read.
    a_read_drives: assert property (read_req && slave_reply && !refresh_active_line |-> ad_s_oe && !ad_m_oe && ad == ad_s_o)
        else $error("read reply without slave data");
    a_write_quiet: assert property (write_req |-> !ad_s_oe)
        else $error("slave drives during write");
    a_read_master_off: assert property (read_req |-> !ad_m_oe)
        else $error("master drives during read");
    // Write phases carry the master's data; the write qualifier never rides a read strobe.
    a_write_data: assert property (write_req |-> ad_m_oe && ad == ad_m_o)
        else $error("write strobe without master data");
    a_qual_no_read: assert property (write_byte_qualifier |-> !read_req)
        else $error("write qualifier during read strobe");
    a_refresh_quiet: assert property (refresh_active_line |-> !ad_s_oe)
        else $error("slave drives during refresh");
    a_addr_first: assert property ($rose(frame_sync) |-> ad_m_oe && $past(ad_m_oe))
        else $error("frame without address set up");
    a_io_flag: assert property ($rose(frame_sync) |-> io_page_select == (ad[ABMS_IOPAGE_MSB:ABMS_IOPAGE_LSB] == ABMS_IOPAGE_TAG))
        else $error("io page select wrong for address");
endmodule

/* abms_master.sv */
// Master end that runs read, write, read-modify-write and refresh cycles.
`timescale 1ns/100ps
module abms_master import abms_pkg::*; (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Backplane.
    abms_bus_if.master bus,
    // User request.
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [ABMS_AW-1:0] req_addr,
    input wire logic [ABMS_DW-1:0] req_wdata,
    // User answer.
    output logic rsp_valid,
    output logic [ABMS_DW-1:0] rsp_rdata
);
    typedef enum {M_IDLE, M_ADDR, M_FRAME, M_STROBE, M_DROP, M_END} abms_mst_t;
    abms_mst_t st_q;
    logic syn;
    logic reply_s;
    logic [ABMS_DW-1:0] ad_s;
    logic [ABMS_DW-1:0] ad_m1, ad_s2;
    abms_cyc_t kind_q;
    logic [ABMS_AW-1:0] addr_q;
    logic [ABMS_DW-1:0] wdata_q;
    logic phase_wr_q;
    logic [2:0] dly_q;

    abms_sync2 #(.W(1)) u_rsync (.mclk(mclk), .rst(rst), .din(bus.slave_reply), .dout(syn));
    abms_sync2 #(.W(ABMS_DW)) u_dsync (.mclk(mclk), .rst(rst), .din(bus.ad), .dout(ad_s));
    assign reply_s = syn;

    // Sequencer: address, frame, strobe, wait on reply, drop strobe, wait reply low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= M_IDLE;
            kind_q <= ABMS_CYC_READ;
            addr_q <= '0;
            wdata_q <= '0;
            phase_wr_q <= 1'b0;
            dly_q <= 3'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (req_valid) begin
                        kind_q <= abms_cyc_t'(req_kind);
                        addr_q <= req_addr;
                        wdata_q <= req_wdata;
                        phase_wr_q <= (req_kind == 2'(ABMS_CYC_WRITE));
                        dly_q <= ABMS_ADDR_SETUP;
                        st_q <= M_ADDR; // [RL2]
                    end
                end
                M_ADDR: begin
                    if (dly_q != 3'h0) begin
                        dly_q <= dly_q - 3'h1; // [RL3]
                    end else begin
                        st_q <= M_FRAME;
                    end
                end
                M_FRAME: begin
                    st_q <= M_STROBE; // [RL5]
                end
                M_STROBE: begin
                    if (reply_s) begin // [RL13]
                        if (!phase_wr_q) begin
                            rsp_rdata <= ad_s;
                        end
                        st_q <= M_DROP; // [RL8]
                    end
                end
                M_DROP: begin
                    if (!reply_s) begin
                        if (kind_q == ABMS_CYC_RMW && !phase_wr_q) begin
                            phase_wr_q <= 1'b1; // [RL9]
                            st_q <= M_STROBE;
                        end else begin
                            st_q <= M_END;
                        end
                    end
                end
                M_END: begin
                    rsp_valid <= 1'b1;
                    st_q <= M_IDLE;
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    // Address while selecting, write data only once a write strobe phase runs.
    assign ad_m1 = (phase_wr_q && (st_q == M_STROBE || st_q == M_DROP)) ? wdata_q : addr_q;
    assign ad_s2 = ad_m1;
    assign bus.ad_m_o = ad_s2;
    assign bus.ad_m_oe = (st_q == M_ADDR) || (st_q == M_FRAME)
                         || (phase_wr_q && (st_q == M_STROBE || st_q == M_DROP));
    assign bus.frame_sync = (st_q == M_FRAME) || (st_q == M_STROBE) || (st_q == M_DROP);
    assign bus.read_req = (st_q == M_STROBE) && !phase_wr_q;
    assign bus.write_req = (st_q == M_STROBE) && phase_wr_q;
    assign bus.write_byte_qualifier = (kind_q == ABMS_CYC_WRITE) && (st_q != M_IDLE); // [RL4]
    assign bus.refresh_active_line = (kind_q == ABMS_CYC_REFRESH) && (st_q != M_IDLE); // [RL10]
    assign bus.io_page_select = (st_q != M_IDLE)
        && (addr_q[ABMS_IOPAGE_MSB:ABMS_IOPAGE_LSB] == ABMS_IOPAGE_TAG); // [RL15]
    assign req_ready = (st_q == M_IDLE);
endmodule

/* abms_pkg.sv */
// Package of shared constants and types for the backplane memory slave and its master.
// Behaviour
// RL1: Memory only answers; never starts a cycle.
// RL2: Master drives address before any strobe.
// RL3: Framing strobe latches and decodes address.
// RL4: Cycle type from byte and refresh qualifiers.
// RL5: Read strobe slave-to-master, write master-to-slave.
// RL6: Slave ends each data phase with reply.
// RL7: Reply only with read data or write taken.
// RL8: Master drops strobe, then slave drops reply.
// RL9: Read-modify-write: read then write, one address.
// RL10: Refresh is read handshake, answered with reply.
// RL11: Refresh moves no data, row A1-A6.
// RL12: Master refreshes sixty-four rows per 1.6ms burst; the master here has no refresh timer and refreshes only on request.
// RL13: Master waits for reply, no fixed time.
// RL14: Upper 4K of 32K words is I/O page; code uses the upper 8K of 64K words (bits 15..13).
// RL15: Master flags I/O page addresses with select.
// RL16: Memory may answer non-clashing I/O page addresses.
// RL17: Unselected cycles get no reply, no drive.
package abms_pkg;
    localparam int ABMS_AW = 16;
    localparam int ABMS_DW = 16;
    // Memory size in words held by this board.
    localparam int ABMS_MEM_WORDS = 64;
    localparam int ABMS_MEM_IW = 6;
    // Word address bits 15..13 all ones mark the I/O page.
    localparam logic [2:0] ABMS_IOPAGE_TAG = 3'h7;
    localparam int ABMS_IOPAGE_MSB = 15;
    localparam int ABMS_IOPAGE_LSB = 13;
    // Refresh row field within the address.
    localparam int ABMS_ROW_LSB = 1;
    localparam int ABMS_ROW_W = 6;
    // Refresh burst size and interval.
    localparam int ABMS_REFRESH_ACTIVE_LINE_BURST = 64;
    localparam real ABMS_REFRESH_ACTIVE_LINE_PERIOD_MS = 1.6;
    localparam real ABMS_CLK_MHZ = 250.0;
    localparam int ABMS_REFRESH_ACTIVE_LINE_CYCLES = int'(ABMS_REFRESH_ACTIVE_LINE_PERIOD_MS * 1000.0 * ABMS_CLK_MHZ);
    // Local memory access latency in clocks before reply.
    localparam logic [3:0] ABMS_ACCESS_CYCLES = 4'h3;
    // Master address set-up in clocks before the framing strobe.
    localparam logic [2:0] ABMS_ADDR_SETUP = 3'h3;
    // Base word address of this board and its optional I/O page window.
    localparam logic [ABMS_AW-1:0] ABMS_MEM_BASE = 16'h0000;
    localparam logic [ABMS_AW-1:0] ABMS_IO_WIN = 16'hF000;
    typedef enum logic [1:0] {
        ABMS_CYC_READ,
        ABMS_CYC_WRITE,
        ABMS_CYC_RMW,
        ABMS_CYC_REFRESH
    } abms_cyc_t;
endpackage

/* abms_slave.sv */
// Memory slave end of the backplane bus with local word storage.
`timescale 1ns/100ps
module abms_slave import abms_pkg::*; (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Backplane.
    abms_bus_if.slave bus,
    // User side configuration and status.
    input wire logic io_win_en,
    output logic [1:0] last_cycle,
    output logic [ABMS_ROW_W-1:0] last_row,
    output logic busy
);
    typedef enum {S_IDLE, S_ADDR, S_WAIT, S_ACCESS, S_REPLY} abms_sst_t;
    abms_sst_t st_q;
    logic [ABMS_DW+5:0] raw;
    logic [ABMS_DW+5:0] syn;
    logic [ABMS_DW-1:0] ad_s;
    logic sync_s, rd_s, wr_s, wrqual_s, ref_s, bs_s;
    logic [ABMS_DW-1:0] mem_q [ABMS_MEM_WORDS];
    logic [ABMS_AW-1:0] addr_q;
    logic sel_q;
    logic [3:0] lat_q;
    logic is_rd_q;
    logic is_ref_q;
    logic [ABMS_DW-1:0] rdata_q;
    logic drive_q;
    logic sel_d;
    abms_cyc_t cyc_d;
    abms_cyc_t cyc_q;

    // All bus pins pass two flops before use.
    assign raw = {bus.ad, bus.frame_sync, bus.read_req, bus.write_req,
                  bus.write_byte_qualifier, bus.refresh_active_line, bus.io_page_select};
    abms_sync2 #(.W(ABMS_DW + 6)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din(raw),
        .dout(syn)
    );
    assign {ad_s, sync_s, rd_s, wr_s, wrqual_s, ref_s, bs_s} = syn;

    // Decode: memory space below I/O page, plus one optional non-clashing window.
    always_comb begin
        if (ad_s[ABMS_IOPAGE_MSB:ABMS_IOPAGE_LSB] != ABMS_IOPAGE_TAG) begin // [RL14]
            sel_d = (ad_s[ABMS_AW-1:ABMS_MEM_IW] == ABMS_MEM_BASE[ABMS_AW-1:ABMS_MEM_IW]);
        end else if (io_win_en && bs_s) begin // [RL16]
            sel_d = (ad_s[ABMS_AW-1:ABMS_MEM_IW] == ABMS_IO_WIN[ABMS_AW-1:ABMS_MEM_IW]);
        end else begin
            sel_d = 1'b0;
        end
    end

    // Cycle class from the two qualifier lines.
    always_comb begin
        if (ref_s) begin
            cyc_d = ABMS_CYC_REFRESH; // [RL4]
        end else if (wrqual_s) begin
            cyc_d = ABMS_CYC_WRITE;
        end else begin
            cyc_d = ABMS_CYC_READ;
        end
    end

    // Handshake sequencer; leaves idle only on master framing.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= S_IDLE;
            addr_q <= '0;
            sel_q <= 1'b0;
            cyc_q <= ABMS_CYC_READ;
            lat_q <= 4'h0;
            is_rd_q <= 1'b0;
            is_ref_q <= 1'b0;
        end else begin
            case (st_q)
                // The address is taken from the sample that first shows the frame,
                // because the master releases the lines on a read strobe, or drives write data on them on a write strobe, once its strobe phase starts.
                S_IDLE: begin
                    if (sync_s) begin // [RL1]
                        addr_q <= ad_s; // [RL3]
                        sel_q <= sel_d || ref_s;
                        cyc_q <= cyc_d;
                        st_q <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    st_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (!sync_s) begin
                        st_q <= S_IDLE;
                    end else if (sel_q && (rd_s || wr_s)) begin // [RL5] [RL17]
                        is_rd_q <= rd_s;
                        is_ref_q <= ref_s;
                        lat_q <= ABMS_ACCESS_CYCLES;
                        st_q <= S_ACCESS;
                    end
                end
                S_ACCESS: begin
                    if (lat_q != 4'h0) begin
                        lat_q <= lat_q - 4'h1; // [RL13]
                    end else begin
                        st_q <= S_REPLY; // [RL6]
                    end
                end
                S_REPLY: begin
                    if (!rd_s && !wr_s) begin // [RL8]
                        if (is_rd_q && !is_ref_q && cyc_q == ABMS_CYC_READ) begin
                            cyc_q <= ABMS_CYC_RMW; // [RL9]
                        end
                        st_q <= S_WAIT; // [RL9]
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Storage access: read data latched, write data taken before reply.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (st_q == S_ACCESS && lat_q == 4'h0 && !is_ref_q) begin // [RL11]
            if (is_rd_q) begin
                rdata_q <= mem_q[addr_q[ABMS_MEM_IW-1:0]]; // [RL7]
            end else begin
                mem_q[addr_q[ABMS_MEM_IW-1:0]] <= ad_s; // [RL7]
            end
        end
    end

    // Data drivers on only for a selected, non-refresh read in reply.
    always_ff @(posedge mclk) begin
        if (rst) begin
            drive_q <= 1'b0;
        end else begin
            if (st_q == S_ACCESS && lat_q == 4'h0 && is_rd_q && !is_ref_q) begin // [RL11]
                drive_q <= 1'b1;
            end else if (st_q == S_REPLY && !rd_s) begin // [RL8]
                drive_q <= 1'b0;
            end
        end
    end

    // Status: last cycle class and last refreshed row.
    always_ff @(posedge mclk) begin
        if (rst) begin
            last_cycle <= 2'h0;
            last_row <= '0;
        end else if (st_q == S_REPLY && !rd_s && !wr_s) begin
            last_cycle <= cyc_q;
            if (is_ref_q) begin
                last_row <= addr_q[ABMS_ROW_LSB +: ABMS_ROW_W]; // [RL11]
            end
        end
    end

    assign bus.ad_s_o = rdata_q;
    assign bus.ad_s_oe = drive_q; // [RL17]
    assign bus.slave_reply = (st_q == S_REPLY) && drive_q == is_rd_q && !is_ref_q
                             || (st_q == S_REPLY && is_ref_q); // [RL7] [RL10]
    assign busy = (st_q != S_IDLE);
endmodule

/* abms_sync2.sv */
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/100ps
module abms_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Raw and synchronised levels.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage.
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* tb_async_backplane_memory_slave.sv */
// Self-checking testbench joining the master and memory slave ends.
`timescale 1ns/100ps
module tb_async_backplane_memory_slave;
    import abms_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic io_win_en = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic [ABMS_AW-1:0] req_addr = 16'h0000;
    logic [ABMS_DW-1:0] req_wdata = 16'h0000;
    logic req_ready, rsp_valid, busy;
    logic [ABMS_DW-1:0] rsp_rdata;
    logic [1:0] last_cycle;
    logic [ABMS_ROW_W-1:0] last_row;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Clock of 4 ns period.
    always #2 mclk = ~mclk;
    abms_bus_if abms_bus_if_inst ();
    abms_slave abms_slave_inst (.mclk(mclk), .rst(rst), .bus(abms_bus_if_inst.slave),
        .io_win_en(io_win_en), .last_cycle(last_cycle), .last_row(last_row), .busy(busy));
    abms_master abms_master_inst (.mclk(mclk), .rst(rst), .bus(abms_bus_if_inst.master),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    abms_bus_sva abms_bus_sva_inst (.mclk(mclk), .rst(rst), .ad_m_o(abms_bus_if_inst.ad_m_o),
        .ad_m_oe(abms_bus_if_inst.ad_m_oe), .ad_s_o(abms_bus_if_inst.ad_s_o),
        .ad_s_oe(abms_bus_if_inst.ad_s_oe), .ad(abms_bus_if_inst.ad),
        .frame_sync(abms_bus_if_inst.frame_sync), .read_req(abms_bus_if_inst.read_req),
        .write_req(abms_bus_if_inst.write_req),
        .write_byte_qualifier(abms_bus_if_inst.write_byte_qualifier),
        .refresh_active_line(abms_bus_if_inst.refresh_active_line),
        .io_page_select(abms_bus_if_inst.io_page_select),
        .slave_reply(abms_bus_if_inst.slave_reply));
    // Reports the verdict and ends the run.
    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Cuts a hung run short.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    // Holds reset for four cycles.
    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
    endtask
    // Issues one request and waits a bounded time for its answer.
    task automatic do_req(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d,
        input int lim, output logic got, output logic loud, output logic [15:0] rd);
        got = 1'b0;
        loud = 1'b0;
        rd = 16'h0000;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_addr <= a;
        req_wdata <= d;
        @(posedge mclk);
        req_valid <= 1'b0;
        for (int n = 0; n < lim && !got; n++) begin
            @(negedge mclk);
            if (abms_bus_if_inst.slave_reply !== 1'b0 || abms_bus_if_inst.ad_s_oe !== 1'b0) loud = 1'b1;
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                rd = rsp_rdata;
            end
        end
    endtask
    // Runs a selected cycle and checks answer and class.
    task automatic run_ok(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] rd);
        logic got, loud;
        do_req(k, a, d, 300, got, loud, rd);
        check("answered", {15'h0, got}, 16'h0001);
        check("cycle class", {14'h0, last_cycle}, {14'h0, k});
        repeat (3) @(negedge mclk);
        check("idle after", {14'h0, busy, req_ready}, 16'h0001);
    endtask
    // Writes both ends of memory and reads them back.
    task automatic t_write_read();
        logic [15:0] rd;
        run_ok(ABMS_CYC_WRITE, 16'h0000, 16'h1234, rd);
        run_ok(ABMS_CYC_WRITE, 16'h003F, 16'hBEEF, rd);
        run_ok(ABMS_CYC_READ, 16'h0000, 16'h0000, rd);
        check("read lo", rd, 16'h1234);
        run_ok(ABMS_CYC_READ, 16'h003F, 16'h0000, rd);
        check("read hi", rd, 16'hBEEF);
    endtask
    // Read-modify-write returns old data and stores new.
    task automatic t_rmw();
        logic [15:0] rd;
        run_ok(ABMS_CYC_WRITE, 16'h0005, 16'hA5A5, rd);
        run_ok(ABMS_CYC_RMW, 16'h0005, 16'h5A5A, rd);
        check("rmw old", rd, 16'hA5A5);
        run_ok(ABMS_CYC_READ, 16'h0005, 16'h0000, rd);
        check("rmw new", rd, 16'h5A5A);
    endtask
    // Refresh rows from the address field; memory left untouched.
    task automatic t_refresh();
        logic [15:0] rd;
        logic [15:0] rows [3] = '{16'h007E, 16'h0002, 16'hFF81};
        logic [15:0] a;
        run_ok(ABMS_CYC_WRITE, 16'h0007, 16'hC3C3, rd);
        foreach (rows[i]) begin
            run_ok(ABMS_CYC_REFRESH, rows[i], 16'hFFFF, rd);
            check("row", {10'h0, last_row}, {10'h0, rows[i][6:1]});
        end
        // A full burst of refresh cycles, one for every row.
        for (int r = 0; r < ABMS_REFRESH_ACTIVE_LINE_BURST; r++) begin
            a = {9'h1FE, 6'(r), 1'b1};
            run_ok(ABMS_CYC_REFRESH, a, 16'h0000, rd);
            check("burst row", {10'h0, last_row}, {10'h0, 6'(r)});
        end
        run_ok(ABMS_CYC_READ, 16'h0007, 16'h0000, rd);
        check("kept", rd, 16'hC3C3);
    endtask
    // I/O page window answers only when enabled; unselected stays silent.
    task automatic t_iopage();
        logic [15:0] rd;
        logic got, loud;
        @(posedge mclk);
        io_win_en <= 1'b1;
        run_ok(ABMS_CYC_WRITE, 16'hF003, 16'h0F0F, rd);
        run_ok(ABMS_CYC_READ, 16'hF003, 16'h0000, rd);
        check("io read", rd, 16'h0F0F);
        do_req(ABMS_CYC_READ, 16'h0040, 16'h0000, 60, got, loud, rd);
        check("gap quiet", {14'h0, got, loud}, 16'h0000);
        do_reset();
        io_win_en <= 1'b0;
        do_req(ABMS_CYC_READ, 16'hF003, 16'h0000, 60, got, loud, rd);
        check("io off quiet", {14'h0, got, loud}, 16'h0000);
        do_reset();
    endtask
    // Main sequence.
    initial begin
        do_reset();
        t_write_read();
        t_rmw();
        t_refresh();
        t_iopage();
        print_verdict();
    end
endmodule
